// File: rtl/cell_meas_defines.svh
// Operation
// - One converter time-shared over all analog sources
// - Cell slots select adjacent sense-input pairs
// - Corrected cell result is 16-bit millivolts
// - Raw 24-bit code kept in 32-bit word
// - Cell conversions clip at five-times-reference full scale
// - Loop: 14 cells, pin, internal, regulator, ground, auxiliary slots
// - Shared slots complete full set every three loops
// - Slots per loop: 18 plus up to three
// - Slot lasts 3 ms or 1.5 ms
// - Programmable idle slots padded after measurements
// - Cell mask suppresses protection on unused inputs
// - Both results produced for every sense input
// - Interconnect voltage reported with synchronous current
// - Current sample stored paired with each cell
`ifndef CELL_MEAS_DEFINES_SVH
`define CELL_MEAS_DEFINES_SVH

`define CLK_FREQ_MHZ       25
`define SLOT_LONG_US       3000
`define SLOT_SHORT_US      1500
`define SLOT_LONG_CYCLES   (`SLOT_LONG_US * `CLK_FREQ_MHZ)
`define SLOT_SHORT_CYCLES  (`SLOT_SHORT_US * `CLK_FREQ_MHZ)

`define NUM_CELLS          14
`define NUM_AUX            9
`define NUM_CHANNELS       29
`define BASE_SLOTS         18
`define MAX_AUX_SLOTS      3
`define ROTATE_LOOPS       3
`define CH_PIN_BASE        14
`define CH_INT_BASE        17
`define CH_AUX_BASE        20
`define CH_REGULATOR       18
`define CH_GROUND          19
`define SLOT_PIN           14
`define SLOT_INT           15
`define SLOT_CHECK_A       16
`define SLOT_CHECK_B       17

`define ADDR_CTRL          12'h000
`define ADDR_CELL_MASK     12'h004
`define ADDR_AUX_EN        12'h008
`define ADDR_TRIM          12'h00C
`define ADDR_STATUS        12'h010
`define ADDR_MV_BASE       12'h100
`define ADDR_RAW_BASE      12'h200
`define ADDR_PAIR_BASE     12'h300

`define CTRL_RUN_BIT       0
`define CTRL_FAST_BIT      1
`define CTRL_IDLE_LSB      4
`define CTRL_IDLE_MSB      11
`define TRIM_GAIN_LSB      0
`define TRIM_GAIN_MSB      15
`define TRIM_OFFS_LSB      16
`define TRIM_OFFS_MSB      31

`define CTRL_RESET         32'h0000_0000
`define CELL_MASK_RESET    14'h3FFF
`define AUX_EN_RESET       9'h000
`define TRIM_RESET         32'h0000_8000
`define GAIN_SHIFT         15
`define FULL_SCALE_MV      6250
`define FULL_SCALE_CODE    24'h7FFFFF

`endif

// File: rtl/cell_meas_pkg.sv
package cell_meas_pkg;
    typedef enum logic [1:0] {
        ST_STOP    = 2'b00,
        ST_MEASURE = 2'b01,
        ST_PAD     = 2'b10
    } seq_state_e;

    typedef logic [4:0]  channel_t;
    typedef logic [23:0] raw_code_t;
    typedef logic [15:0] millivolt_t;
endpackage

// File: rtl/result_corrector.sv
`timescale 1ns/1ns
`default_nettype none
`include "cell_meas_defines.svh"

module result_corrector (
    // Converter code and trim
    input  wire logic [23:0] raw_in,
    input  wire logic [15:0] gain_in,
    input  wire logic [15:0] offset_in,
    input  wire logic        clip_en_in,
    // Results
    output logic      [15:0] millivolt_out,
    output logic      [31:0] raw_word_out
);
    import cell_meas_pkg::*;

    logic signed [23:0] clipped;
    logic signed [39:0] scaled;
    logic signed [56:0] trimmed;
    logic signed [56:0] biased;

    always_comb begin
        clipped = $signed(raw_in);
        if (clip_en_in && $signed(raw_in) > $signed(`FULL_SCALE_CODE)) begin
            clipped = $signed(`FULL_SCALE_CODE);
        end
    end

    // Code to millivolts, then gain and offset trim
    always_comb begin
        scaled  = 40'(40'(clipped) * 40'sd`FULL_SCALE_MV) >>> 23;
        trimmed = 57'(57'(scaled) * $signed({1'b0, gain_in})) >>> `GAIN_SHIFT;
        biased  = trimmed + 57'($signed(offset_in));
        if (biased > 57'sd32767) begin
            millivolt_out = 16'h7FFF;
        end else if (biased < -57'sd32768) begin
            millivolt_out = 16'h8000;
        end else begin
            millivolt_out = biased[15:0];
        end
    end

    assign raw_word_out = {{8{raw_in[23]}}, raw_in};
endmodule
`default_nettype wire

// File: rtl/cell_meas_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "cell_meas_defines.svh"

module cell_meas_sequencer #(
    parameter int SLOT_LONG_CYCLES  = `SLOT_LONG_CYCLES,
    parameter int SLOT_SHORT_CYCLES = `SLOT_SHORT_CYCLES
) (
    // Clock and reset
    input  wire logic                     clock_in,
    input  wire logic                     sys_rst_in,
    // APB slave
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [11:0]              paddr_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out,
    // Converter and input switch
    output logic                          adc_start_out,
    output cell_meas_pkg::channel_t       adc_channel_out,
    output logic                          adc_fast_out,
    input  wire cell_meas_pkg::raw_code_t adc_data_in,
    input  wire logic                     adc_valid_in,
    input  wire logic [15:0]              current_sample_in,
    // Protection side
    output logic      [13:0]              cell_protect_en_out,
    output logic                          loop_done_out
);
    import cell_meas_pkg::*;

    seq_state_e  state;
    logic [31:0] ctrl;
    logic [13:0] cell_mask;
    logic [8:0]  aux_en;
    logic [31:0] trim;
    logic [16:0] slot_timer;
    logic [4:0]  slot;
    logic [7:0]  pad_left;
    logic [1:0]  phase;
    logic [15:0] loop_count;
    logic [23:0] held_raw;
    logic [15:0] held_current;
    logic        held_ok;
    channel_t    cur_channel;

    logic [15:0] mv_mem   [`NUM_CHANNELS];
    logic [31:0] raw_mem  [`NUM_CHANNELS];
    logic [15:0] curr_mem [`NUM_CELLS];

    logic [15:0] corr_mv;
    logic [31:0] corr_raw;
    logic [16:0] next_slot_len;
    logic [4:0]  loop_slots;
    logic        slot_end;
    logic        setup;
    logic        launch;

    function automatic logic [3:0] count_ones(input logic [8:0] bits);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < `NUM_AUX; i++) begin
            n = n + 4'(bits[i]);
        end
        return n;
    endfunction

    // Index of the nth enabled auxiliary input
    function automatic logic [3:0] nth_enabled(input logic [8:0] bits, input logic [3:0] nth);
        logic [3:0] seen;
        logic [3:0] pick;
        seen = 4'h0;
        pick = 4'h0;
        for (int i = 0; i < `NUM_AUX; i++) begin
            if (bits[i]) begin
                if (seen == nth) begin
                    pick = 4'(i);
                end
                seen = seen + 4'h1;
            end
        end
        return pick;
    endfunction

    function automatic channel_t slot_channel(input logic [4:0] s, input logic [1:0] ph,
                                              input logic [8:0] bits);
        logic [3:0] cnt;
        logic [3:0] pos;
        channel_t   ch;
        cnt = count_ones(bits);
        ch  = 5'(s);
        if (s == 5'(`SLOT_PIN)) begin
            ch = 5'(`CH_PIN_BASE) + 5'(ph);
        end else if (s == 5'(`SLOT_INT)) begin
            ch = 5'(`CH_INT_BASE) + 5'(ph);
        end else if (s == 5'(`SLOT_CHECK_A)) begin
            ch = 5'(`CH_REGULATOR);
        end else if (s == 5'(`SLOT_CHECK_B)) begin
            ch = 5'(`CH_GROUND);
        end else if (s >= 5'(`BASE_SLOTS)) begin
            // Phase-major walk so three loops cover up to nine inputs
            pos = 4'((4'(ph) * 4'd3 + 4'(s - 5'(`BASE_SLOTS))) % ((cnt == 4'h0) ? 4'h1 : cnt));
            ch  = 5'(`CH_AUX_BASE) + 5'(nth_enabled(bits, pos));
        end
        return ch;
    endfunction

    function automatic logic is_readable(input logic [11:0] a);
        logic [9:0] idx;
        idx = a[11:2] & 10'h03F;
        is_readable = (a == `ADDR_CTRL) || (a == `ADDR_CELL_MASK) || (a == `ADDR_AUX_EN) ||
                      (a == `ADDR_TRIM) || (a == `ADDR_STATUS) ||
                      ((a[11:8] == 4'h1 || a[11:8] == 4'h2) && idx < 10'(`NUM_CHANNELS)) ||
                      (a[11:8] == 4'h3 && idx < 10'(`NUM_CELLS));
    endfunction

    always_comb begin
        logic [3:0] na;
        na         = count_ones(aux_en);
        loop_slots = 5'(`BASE_SLOTS) + ((na > 4'(`MAX_AUX_SLOTS)) ? 5'(`MAX_AUX_SLOTS) : 5'(na));
    end

    assign next_slot_len = ctrl[`CTRL_FAST_BIT] ? 17'(SLOT_SHORT_CYCLES - 1)
                                                : 17'(SLOT_LONG_CYCLES - 1);
    assign slot_end      = (state != ST_STOP) && (slot_timer == 17'h0);
    assign setup         = psel_in && !penable_in;
    assign launch        = ctrl[`CTRL_RUN_BIT] &&
                           ((state == ST_STOP) ||
                            (state == ST_MEASURE && slot_end && slot + 5'h1 < loop_slots));

    result_corrector u_corr (
        .raw_in        (held_raw),
        .gain_in       (trim[`TRIM_GAIN_MSB:`TRIM_GAIN_LSB]),
        .offset_in     (trim[`TRIM_OFFS_MSB:`TRIM_OFFS_LSB]),
        .clip_en_in    (cur_channel < 5'(`NUM_CELLS)),
        .millivolt_out (corr_mv),
        .raw_word_out  (corr_raw)
    );

    // Sequencer state, slot timing and rotation
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state       <= ST_STOP;
            slot_timer  <= 17'h0;
            slot        <= 5'h0;
            pad_left    <= 8'h0;
            phase       <= 2'h0;
            loop_count  <= 16'h0;
            cur_channel <= 5'h0;
        end else if (!ctrl[`CTRL_RUN_BIT]) begin
            state      <= ST_STOP;
            slot_timer <= 17'h0;
            slot       <= 5'h0;
            phase      <= 2'h0;
        end else begin
            unique case (state)
                ST_STOP: begin
                    state       <= ST_MEASURE;
                    slot        <= 5'h0;
                    slot_timer  <= next_slot_len;
                    cur_channel <= slot_channel(5'h0, phase, aux_en);
                end
                ST_MEASURE: begin
                    if (slot_timer != 17'h0) begin
                        slot_timer <= slot_timer - 17'h1;
                    end else if (slot + 5'h1 < loop_slots) begin
                        slot        <= slot + 5'h1;
                        slot_timer  <= next_slot_len;
                        cur_channel <= slot_channel(slot + 5'h1, phase, aux_en);
                    end else if (ctrl[`CTRL_IDLE_MSB:`CTRL_IDLE_LSB] != 8'h0) begin
                        state      <= ST_PAD;
                        pad_left   <= ctrl[`CTRL_IDLE_MSB:`CTRL_IDLE_LSB] - 8'h1;
                        slot_timer <= next_slot_len;
                    end else begin
                        state <= ST_STOP;
                        phase <= (phase == 2'(`ROTATE_LOOPS - 1)) ? 2'h0 : phase + 2'h1;
                        loop_count <= loop_count + 16'h1;
                    end
                end
                ST_PAD: begin
                    if (slot_timer != 17'h0) begin
                        slot_timer <= slot_timer - 17'h1;
                    end else if (pad_left != 8'h0) begin
                        pad_left   <= pad_left - 8'h1;
                        slot_timer <= next_slot_len;
                    end else begin
                        state <= ST_STOP;
                        phase <= (phase == 2'(`ROTATE_LOOPS - 1)) ? 2'h0 : phase + 2'h1;
                        loop_count <= loop_count + 16'h1;
                    end
                end
                default: begin
                    state <= ST_STOP;
                end
            endcase
        end
    end

    // Converter request for each measurement slot
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            adc_start_out   <= 1'b0;
            adc_channel_out <= 5'h0;
            adc_fast_out    <= 1'b0;
            loop_done_out   <= 1'b0;
        end else begin
            adc_start_out   <= launch;
            // Channel held for the whole slot
            if (launch) begin
                adc_channel_out <= (state == ST_STOP) ? slot_channel(5'h0, phase, aux_en)
                                                      : slot_channel(slot + 5'h1, phase, aux_en);
            end
            adc_fast_out    <= ctrl[`CTRL_FAST_BIT];
            loop_done_out   <= ctrl[`CTRL_RUN_BIT] && slot_end &&
                               ((state == ST_PAD && pad_left == 8'h0) ||
                                (state == ST_MEASURE && slot + 5'h1 >= loop_slots &&
                                 ctrl[`CTRL_IDLE_MSB:`CTRL_IDLE_LSB] == 8'h0));
        end
    end

    // Converter code and current captured together
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            held_raw     <= 24'h0;
            held_current <= 16'h0;
            held_ok      <= 1'b0;
        end else if (adc_start_out) begin
            held_ok <= 1'b0;
        end else if (adc_valid_in && state == ST_MEASURE) begin
            held_raw     <= adc_data_in;
            held_current <= current_sample_in;
            held_ok      <= 1'b1;
        end
    end

    // Results commit only at slot end
    always_ff @(posedge clock_in) begin
        if (state == ST_MEASURE && slot_end && held_ok) begin
            mv_mem[cur_channel]  <= corr_mv;
            raw_mem[cur_channel] <= corr_raw;
            if (cur_channel < 5'(`NUM_CELLS)) begin
                curr_mem[4'(cur_channel)] <= held_current;
            end
        end
    end

    // Software registers
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl      <= `CTRL_RESET;
            cell_mask <= `CELL_MASK_RESET;
            aux_en    <= `AUX_EN_RESET;
            trim      <= `TRIM_RESET;
        end else if (psel_in && penable_in && pready_out && pwrite_in) begin
            unique case (paddr_in)
                `ADDR_CTRL:      ctrl      <= pwdata_in & 32'h0000_0FF3;
                `ADDR_CELL_MASK: cell_mask <= pwdata_in[13:0];
                `ADDR_AUX_EN:    aux_en    <= pwdata_in[8:0];
                `ADDR_TRIM:      trim      <= pwdata_in;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cell_protect_en_out <= `CELL_MASK_RESET;
        end else begin
            cell_protect_en_out <= cell_mask;
        end
    end

    // APB answer: one wait-free access cycle
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else begin
            pready_out  <= setup;
            pslverr_out <= setup && (!is_readable(paddr_in) ||
                                     (pwrite_in && paddr_in[11:8] != 4'h0) ||
                                     (pwrite_in && paddr_in == `ADDR_STATUS));
            prdata_out  <= 32'h0;
            if (setup && !pwrite_in && is_readable(paddr_in)) begin
                unique case (paddr_in[11:8])
                    4'h1: prdata_out <= {16'h0, mv_mem[5'(paddr_in[7:2])]};
                    4'h2: prdata_out <= raw_mem[5'(paddr_in[7:2])];
                    4'h3: prdata_out <= {curr_mem[4'(paddr_in[5:2])],
                                         mv_mem[5'(paddr_in[5:2])]};
                    default: begin
                        unique case (paddr_in)
                            `ADDR_CTRL:      prdata_out <= ctrl;
                            `ADDR_CELL_MASK: prdata_out <= {18'h0, cell_mask};
                            `ADDR_AUX_EN:    prdata_out <= {23'h0, aux_en};
                            `ADDR_TRIM:      prdata_out <= trim;
                            default:         prdata_out <= {loop_count, 1'b0, state,
                                                            phase, held_ok, 5'h0, slot};
                        endcase
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/cell_meas_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cell_meas_checker #(
    parameter int SLOT_LONG_CYCLES  = 75000,
    parameter int SLOT_SHORT_CYCLES = 37500
) (
    // Clock, reset, bus
    input wire logic                    clock_in,
    input wire logic                    sys_rst_in,
    input wire logic                    psel_in,
    input wire logic                    penable_in,
    input wire logic                    pwrite_in,
    input wire logic [11:0]             paddr_in,
    // Converter and protection
    input wire logic                    adc_start_out,
    input wire cell_meas_pkg::channel_t adc_channel_out,
    input wire logic                    adc_fast_out,
    input wire logic [13:0]             cell_protect_en_out,
    input wire logic                    loop_done_out
);
    import cell_meas_pkg::*;
    channel_t    last_ch;
    channel_t    last_pin;
    logic [31:0] gap;
    logic [5:0]  nstarts;
    wire         mask_wr = psel_in && penable_in && pwrite_in && paddr_in == 12'h004;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            last_ch <= 5'h1F;
            gap     <= 32'h0;
        end else if (adc_start_out) begin
            last_ch <= adc_channel_out;
            gap     <= 32'h0;
        end else begin
            gap <= gap + 32'h1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            last_pin <= 5'h0;
        else if (adc_start_out && adc_channel_out inside {[14:16]})
            last_pin <= adc_channel_out;
    end

    // Starts seen since the previous loop end
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            nstarts <= 6'h0;
        else if (loop_done_out)
            nstarts <= {5'h0, adc_start_out};
        else if (adc_start_out)
            nstarts <= nstarts + 6'h1;
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_new_slot;
        adc_start_out && last_ch != 5'h1F;
    endsequence
    sequence s_no_mask_wr;
        !mask_wr ##1 !mask_wr;
    endsequence

    chan_range_a: assert property (adc_start_out |-> adc_channel_out <= 5'd28)
        else $error("channel code out of range");
    cell_order_a: assert property (s_new_slot ##0 last_ch < 5'd13
        |-> adc_channel_out == last_ch + 5'd1) else $error("cell slots out of order");
    slot_order_a: assert property (s_new_slot |->
        (last_ch != 5'd13 || adc_channel_out inside {[14:16]}) &&
        (!(last_ch inside {[14:16]}) || adc_channel_out inside {[17:19]}))
        else $error("pin or internal slot misplaced");
    rotate_a: assert property (adc_start_out && adc_channel_out inside {[14:16]}
        && last_pin != 5'h0 |-> adc_channel_out == (last_pin == 5'd16 ? 5'd14 : last_pin + 5'd1))
        else $error("pin slot rotation broken");
    loop_size_a: assert property (loop_done_out |-> nstarts inside {[18:21]})
        else $error("slot count per loop wrong");
    slot_len_a: assert property (s_new_slot ##0 adc_channel_out != 5'd0
        |-> gap == (adc_fast_out ? SLOT_SHORT_CYCLES : SLOT_LONG_CYCLES) - 1)
        else $error("slot length wrong");
    chan_hold_a: assert property (adc_start_out |=> $stable(adc_channel_out)[*8])
        else $error("channel changed inside slot");
    mask_hold_a: assert property (s_no_mask_wr |=> $stable(cell_protect_en_out))
        else $error("protection enables changed without write");
endmodule

bind cell_meas_sequencer cell_meas_checker #(
    .SLOT_LONG_CYCLES (SLOT_LONG_CYCLES),
    .SLOT_SHORT_CYCLES(SLOT_SHORT_CYCLES)
) checker_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .adc_start_out(adc_start_out), .adc_channel_out(adc_channel_out),
    .adc_fast_out(adc_fast_out), .cell_protect_en_out(cell_protect_en_out),
    .loop_done_out(loop_done_out)
);
`default_nettype wire

// File: verif/adc_partner_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_partner_model (
    // Conversion requests
    input  wire logic                    clock_in,
    input  wire logic                    start_in,
    input  wire cell_meas_pkg::channel_t channel_in,
    // Scenario controls
    input  wire logic                    slow_in,
    input  wire cell_meas_pkg::channel_t skip_channel_in,
    // Results
    output cell_meas_pkg::raw_code_t     data_out,
    output logic                         valid_out,
    output logic [15:0]                  current_out
);
    import cell_meas_pkg::*;
    logic        busy     = 1'b0;
    logic [3:0]  wait_cnt = 4'h0;
    channel_t    chan     = 5'h0;
    logic [15:0] ramp     = 16'h0;

    initial begin
        data_out    = 24'h0;
        valid_out   = 1'b0;
        current_out = 16'h0;
    end

    // Current keeps moving; stale data is inverted so it never looks valid
    always @(posedge clock_in) begin
        ramp        <= ramp + 16'h0101;
        current_out <= ramp;
        valid_out   <= 1'b0;
        data_out    <= ~data_out;
        if (start_in) begin
            busy     <= 1'b1;
            chan     <= channel_in;
            wait_cnt <= slow_in ? 4'h5 : 4'h0;
        end else if (busy && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            if (chan != skip_channel_in) begin
                valid_out   <= 1'b1;
                data_out    <= 24'h40_0000 + {19'h0, chan};
                current_out <= {8'hA5, 3'h0, chan};
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/cell_voltage_measurement_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "cell_meas_defines.svh"
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("MISMATCH at %0t: got %0h, expected %0h", $time, (got), (exp)); \
    end \
end

module cell_voltage_measurement_sequencer_tb;
    import cell_meas_pkg::*;
    localparam int LONG  = 20;
    localparam int SHORT = 10;
    logic        clock_in, sys_rst_in, psel, penable, pwrite, pready, pslverr, err;
    logic        adc_start, adc_fast, adc_valid, loop_done, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    channel_t    adc_channel, skip_ch;
    raw_code_t   adc_data;
    logic [15:0] current;
    logic [13:0] protect_en;
    int          mismatches, n_compared, cycles;

    cell_meas_sequencer #(.SLOT_LONG_CYCLES(LONG), .SLOT_SHORT_CYCLES(SHORT)) uut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .adc_start_out(adc_start),
        .adc_channel_out(adc_channel), .adc_fast_out(adc_fast), .adc_data_in(adc_data),
        .adc_valid_in(adc_valid), .current_sample_in(current),
        .cell_protect_en_out(protect_en), .loop_done_out(loop_done)
    );
    adc_partner_model adc (
        .clock_in(clock_in), .start_in(adc_start), .channel_in(adc_channel), .slow_in(slow),
        .skip_channel_in(skip_ch), .data_out(adc_data), .valid_out(adc_valid),
        .current_out(current)
    );

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_reset();
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        sys_rst_in <= 1'b0;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_in);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        k = 0;
        // Look between edges so the answer is read while it stands
        do begin
            @(negedge clock_in);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        @(posedge clock_in);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp)
        `CHK(err, exp_err)
    endtask

    task automatic t_reg_reset();
        rd_chk(`ADDR_CELL_MASK, 32'h0000_3FFF, 1'b0);
        rd_chk(`ADDR_AUX_EN, 32'h0, 1'b0);
        rd_chk(`ADDR_TRIM, 32'h0000_8000, 1'b0);
        rd_chk(12'h020, 32'h0, 1'b1);
        `CHK(protect_en, 14'h3FFF)
        apb(1'b1, `ADDR_STATUS, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
    endtask

    task automatic t_mask();
        apb(1'b1, `ADDR_CELL_MASK, 32'h0000_1555);
        repeat (3) @(negedge clock_in);
        `CHK(protect_en, 14'h1555)
    endtask

    task automatic t_loop(input logic [8:0] aux, input logic fast, input logic [7:0] idle);
        int n, loops, t0, g, len;
        logic [28:0] seen;
        n = 0;
        loops = 0;
        t0 = 0;
        g = 0;
        seen = '0;
        len = ($countones(aux) > 3) ? 21 : 18 + $countones(aux);
        apb(1'b1, `ADDR_AUX_EN, {23'h0, aux});
        apb(1'b1, `ADDR_CTRL, {20'h0, idle, 2'b00, fast, 1'b1});
        while (loops < 3 && g < 4000) begin
            @(negedge clock_in);
            g++;
            if (loop_done === 1'b1) begin
                `CHK(n, len)
                // One restart cycle between loops
                if (loops == 1)
                    `CHK(cycles - t0, (len + idle) * (fast ? SHORT : LONG) + 1)
                t0 = cycles;
                loops++;
                n = 0;
            end
            if (adc_start === 1'b1 && loops < 3) begin
                n++;
                seen[adc_channel] = 1'b1;
                `CHK(adc_fast, fast)
            end
        end
        `CHK(seen, {aux, 20'hF_FFFF})
    endtask

    task automatic t_results(input int off);
        for (int c = 0; c < 20; c++) begin
            rd_chk(`ADDR_MV_BASE + 12'(4 * c), 32'(3125 + off), 1'b0);
            rd_chk(`ADDR_RAW_BASE + 12'(4 * c), 32'h0040_0000 + 32'(c), 1'b0);
            if (c < 14)
                rd_chk(`ADDR_PAIR_BASE + 12'(4 * c), {16'hA500 + 16'(c), 16'(3125 + off)}, 1'b0);
        end
        apb(1'b1, `ADDR_MV_BASE, 32'h0);
        `CHK(err, 1'b1)
    endtask

    task automatic t_skip();
        int i, d;
        slow <= 1'b1;
        t_loop(9'h002, 1'b1, 8'h01);
        t_results(0);
        skip_ch <= 5'd5;
        apb(1'b1, `ADDR_TRIM, 32'h0064_8000);
        d = 0;
        for (i = 0; i < 2000 && d < 2; i++) begin
            @(negedge clock_in);
            if (loop_done === 1'b1)
                d++;
        end
        rd_chk(`ADDR_MV_BASE + 12'd20, 32'd3125, 1'b0);
        rd_chk(`ADDR_MV_BASE + 12'd16, 32'd3225, 1'b0);
    endtask

    initial begin
        sys_rst_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        slow = 1'b0;
        skip_ch = 5'h1F;
        do_reset();
        t_reg_reset();
        t_mask();
        t_loop(9'h000, 1'b0, 8'h00);
        t_results(0);
        do_reset();
        t_loop(9'h003, 1'b1, 8'h02);
        do_reset();
        t_loop(9'h1F1, 1'b1, 8'h00);
        do_reset();
        t_skip();
        end_sim();
    end
endmodule
`default_nettype wire
